//--- rspi_indicator.sv
// Signal-strength PWM indicator: duty from last packet, hold timer, pin.
module rspi_indicator
    import rspi_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = rspi_pkg::STEP_CYC,
    parameter int unsigned HOLD_CYCLES = rspi_pkg::HOLD_UNIT_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       pkt_rx_i,
    input  wire logic [7:0] pkt_db_above_i,
    input  wire logic       hold_time_config_command_i,
    input  wire logic [7:0] hold_time_wdata_i,
    output logic      [7:0] signal_pwm_hold_time_o,
    input  wire logic       func_sel_wr_i,
    input  wire logic       pwm_pin_function_select_i,
    output logic            pwm_pin_function_select_o,
    output logic            signal_strength_pwm_out_o,
    output logic            indicator_active_o
);
    logic        rst_q1;
    logic        rst_n;
    rspi_tick_if tick ();

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    rspi_pwm_timebase #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timebase (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .tick       (tick)
    );

    // Duty mapping: steps = 40 * (295 + 17.5 * dB) / 10.24 / 100.
    logic signed [31:0] duty_num;
    rspi_step_t         calc_duty;

    always_comb begin
        duty_num = (DUTY_OFS_X10 + DUTY_SLOPE_X10
                    * 32'(signed'(pkt_db_above_i)))
                   * int'(STEP_COUNT);
        if (duty_num <= 0) begin
            calc_duty = 6'h00;
        end else if (duty_num / DUTY_DIV_X1000 >= int'(MAX_STEPS)) begin
            calc_duty = MAX_STEPS;
        end else begin
            calc_duty = 6'(duty_num / DUTY_DIV_X1000);
        end
    end

    // Configuration, pending packet, hold timer and output state.
    logic [7:0]  hold_time;
    logic [7:0]  next_hold_time;
    logic        func_sel;
    logic        next_func_sel;
    logic        pend;
    logic        next_pend;
    rspi_step_t  pend_duty;
    rspi_step_t  next_pend_duty;
    rspi_step_t  duty;
    rspi_step_t  next_duty;
    logic        active;
    logic        next_active;
    logic [31:0] unit_cyc;
    logic [31:0] next_unit_cyc;
    logic [7:0]  units;
    logic [7:0]  next_units;
    logic        expired;
    logic        hold_run;
    logic        pwm;
    logic        next_pwm;

    always_comb begin
        next_hold_time = hold_time_config_command_i ? hold_time_wdata_i
                                                    : hold_time;
        next_func_sel  = func_sel_wr_i ? pwm_pin_function_select_i
                                       : func_sel;
        next_pend      = pend;
        next_pend_duty = pend_duty;
        next_duty      = duty;
        next_active    = active;
        next_unit_cyc  = unit_cyc;
        next_units     = units;
        expired        = (hold_time != HOLD_FOREVER)
                         && (units >= hold_time);
        // The unit count saturates so that a long unlimited hold, later
        // shortened, counts as expired instead of wrapping round to zero.
        hold_run       = active && !expired && (units != HOLD_FOREVER);
        if (hold_run) begin
            if (unit_cyc == HOLD_CYCLES - 1) begin
                next_unit_cyc = 32'h0000_0000;
                next_units    = units + 8'h01;
            end else begin
                next_unit_cyc = unit_cyc + 32'h0000_0001;
            end
        end
        if (tick.period_end) begin
            if (pend) begin
                next_duty     = pend_duty;
                next_active   = 1'b1;
                next_pend     = 1'b0;
                next_unit_cyc = 32'h0000_0000;
                next_units    = 8'h00;
            end else if (expired) begin
                next_active = 1'b0;
            end
        end
        // A packet in the loading cycle becomes the next pending value.
        if (pkt_rx_i) begin
            next_pend      = 1'b1;
            next_pend_duty = calc_duty;
        end
        next_pwm = active && func_sel
                   && (tick.step < duty);
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hold_time <= HOLD_RST;
            func_sel  <= FUNC_SEL_RST;
            pend      <= 1'b0;
            pend_duty <= 6'h00;
            duty      <= 6'h00;
            active    <= 1'b0;
            unit_cyc  <= 32'h0000_0000;
            units     <= 8'h00;
            pwm       <= 1'b0;
        end else begin
            hold_time <= next_hold_time;
            func_sel  <= next_func_sel;
            pend      <= next_pend;
            pend_duty <= next_pend_duty;
            duty      <= next_duty;
            active    <= next_active;
            unit_cyc  <= next_unit_cyc;
            units     <= next_units;
            pwm       <= next_pwm;
        end
    end

    assign signal_pwm_hold_time_o    = hold_time;
    assign pwm_pin_function_select_o = func_sel;
    assign signal_strength_pwm_out_o = pwm;
    assign indicator_active_o        = active;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence seq_load;
        tick.period_end && pend;
    endsequence

    sequence seq_expire;
        tick.period_end && !pend && expired;
    endsequence

    sequence seq_unit_done;
        hold_run && (unit_cyc == HOLD_CYCLES - 1)
        && !(tick.period_end && pend);
    endsequence

    AST_SEL_OFF_LOW: assert property (!func_sel |=> !pwm)
        else $error("Pin driven while function is disabled.");
    AST_IDLE_LOW: assert property (!active |=> !pwm)
        else $error("Pin high while indicator is idle.");
    AST_DUTY_MAX: assert property (duty <= MAX_STEPS)
        else $error("Duty above the maximum.");
    AST_STEP_LOW: assert property ((tick.step >= duty) |=> !pwm)
        else $error("Pin high past the duty step.");
    AST_LOAD: assert property (seq_load |=> active
        && (duty == $past(pend_duty)) && (units == 8'h00))
        else $error("Pending duty not loaded at period end.");
    AST_TIMEOUT: assert property (seq_expire |=> !active)
        else $error("Output not forced low after hold time.");
    AST_FOREVER: assert property (
        active && (hold_time == HOLD_FOREVER) |=> active)
        else $error("Output timed out with unlimited hold.");
    AST_HOLD_RST: assert property (
        $rose(rst_n) |-> hold_time == HOLD_RST)
        else $error("Hold time reset value wrong.");
    AST_LOW_DB: assert property (
        signed'(pkt_db_above_i) <= 0 |->
        32'(calc_duty) * 100 < SENS_MAX_PCT * STEP_COUNT)
        else $error("Duty too high at or below sensitivity.");
    AST_DUTY_MAP: assert property (pkt_rx_i ##1 !pkt_rx_i
        |-> pend_duty == $past(calc_duty))
        else $error("Packet duty not latched.");
    AST_UNIT_STEP: assert property (seq_unit_done |=>
        units == $past(units) + 8'h01)
        else $error("Hold timer did not advance one unit.");
    AST_HOLD_WR: assert property (hold_time_config_command_i |=>
        hold_time == $past(hold_time_wdata_i))
        else $error("Hold time write not taken.");
    AST_SEL_WR: assert property (func_sel_wr_i |=>
        func_sel == $past(pwm_pin_function_select_i))
        else $error("Function select write not taken.");
    AST_STEADY: assert property (!tick.period_end |=>
        $stable(active) && $stable(duty))
        else $error("Duty or activity changed inside a period.");
    AST_PEND_SET: assert property (pkt_rx_i |=> pend)
        else $error("Received packet not held as pending.");
    AST_HIGH_STEP: assert property (
        active && func_sel && (tick.step < duty) |=> pwm)
        else $error("Pin low inside the duty steps.");
endmodule : rspi_indicator

//--- rspi_pkg.sv
// Package with the constants of the signal-strength PWM indicator.
package rspi_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned PWM_PERIOD_US   = 8320;
    localparam int unsigned STEP_COUNT      = 40;
    localparam int unsigned STEP_US         = 208;
    localparam int unsigned STEP_CYC        = STEP_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned PERIOD_CYC      = PWM_PERIOD_US * 1000
                                              / CLK_PERIOD_NS;
    localparam int unsigned HOLD_UNIT_MS    = 100;
    localparam int unsigned HOLD_UNIT_CYC   = HOLD_UNIT_MS * 1000000
                                              / CLK_PERIOD_NS;
    localparam int signed   DUTY_OFS_X10    = 2950;
    localparam int signed   DUTY_SLOPE_X10  = 175;
    localparam int signed   DUTY_DIV_X1000  = 10240;
    localparam int unsigned MAX_DUTY_PCT    = 95;
    localparam int unsigned SENS_MAX_PCT    = 29;
    localparam logic [5:0]  MAX_STEPS       = 6'(MAX_DUTY_PCT * STEP_COUNT
                                                  / 100);
    localparam logic [5:0]  LAST_STEP       = 6'(STEP_COUNT - 1);
    localparam logic [7:0]  HOLD_RST        = 8'h28;
    localparam logic [7:0]  HOLD_FOREVER    = 8'hFF;
    localparam logic        FUNC_SEL_RST    = 1'b1;
    typedef logic [5:0] rspi_step_t;
endpackage : rspi_pkg

//--- rspi_pwm_indicator_test.sv
// Self-checking testbench of the signal-strength PWM indicator.
module rssi_pwm_indicator_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rspi_pkg::*;
    localparam int unsigned STEPS_C = 4;
    localparam int unsigned HOLD_C  = 200;
    localparam int unsigned PER     = STEPS_C * STEP_COUNT;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        pkt = 1'b0;
    logic [7:0]  db = 8'h00;
    logic        hwr = 1'b0;
    logic [7:0]  hdat = 8'h00;
    logic [7:0]  hold;
    logic        swr = 1'b0;
    logic        sdat = 1'b0;
    logic        sel;
    logic        pwm;
    logic        act;
    logic        clr = 1'b1;
    logic [15:0] highs;
    int          n_errors = 0;
    int          checked = 0;
    always #12.5 clk = ~clk;
    rspi_indicator #(.STEP_CYCLES(STEPS_C), .HOLD_CYCLES(HOLD_C))
        i_rspi_indicator (
        .core_clk_i(clk), .rstn_i(rstn), .pkt_rx_i(pkt),
        .pkt_db_above_i(db), .hold_time_config_command_i(hwr),
        .hold_time_wdata_i(hdat), .signal_pwm_hold_time_o(hold),
        .func_sel_wr_i(swr), .pwm_pin_function_select_i(sdat),
        .pwm_pin_function_select_o(sel),
        .signal_strength_pwm_out_o(pwm), .indicator_active_o(act));
    rspi_pwm_sampler i_rspi_pwm_sampler (
        .core_clk_i(clk), .pwm_i(pwm), .clear_i(clr), .highs_o(highs));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    function automatic int exp_steps(input int dbv);
        int d;
        d = DUTY_OFS_X10 + DUTY_SLOPE_X10 * dbv;
        if (d <= 0) begin
            return 0;
        end
        d = d * int'(STEP_COUNT) / DUTY_DIV_X1000;
        return (d > int'(MAX_STEPS)) ? int'(MAX_STEPS) : d;
    endfunction : exp_steps
    task automatic wr_hold(input logic [7:0] v);
        hwr = 1'b1;
        hdat = v;
        step(1);
        hwr = 1'b0;
        check("hold readback", {8'h00, hold}, {8'h00, v});
    endtask : wr_hold
    task automatic wr_sel(input logic v);
        swr = 1'b1;
        sdat = v;
        step(1);
        swr = 1'b0;
        check("select readback", {15'h0, sel}, {15'h0, v});
    endtask : wr_sel
    task automatic send(input int dbv);
        pkt = 1'b1;
        db = 8'(dbv);
        step(1);
        pkt = 1'b0;
    endtask : send
    // Counts high cycles over exactly two PWM periods.
    task automatic measure(input int exp);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(2 * PER);
        check("pwm high cycles", highs, 16'(exp));
    endtask : measure
    task automatic t_duty(input int dbv);
        send(dbv);
        step(2 * PER);
        check("active", {15'h0, act}, 16'h0001);
        measure(2 * STEPS_C * exp_steps(dbv));
    endtask : t_duty
    task automatic t_expire(input logic [7:0] hv, input int wait_c);
        wr_hold(hv);
        send(20);
        step(wait_c);
        check("active after hold", {15'h0, act}, 16'h0000);
        measure(0);
    endtask : t_expire
    task automatic t_reset;
        rstn = 1'b0;
        step(8);
        rstn = 1'b1;
        step(3);
        check("hold reset", {8'h00, hold}, {8'h00, HOLD_RST});
        check("select reset", {15'h0, sel}, 16'h0001);
        measure(0);
        check("active reset", {15'h0, act}, 16'h0000);
    endtask : t_reset
    initial begin
        #1000000;
        n_errors++;
        results();
    end
    initial begin
        t_reset();
        wr_hold(HOLD_FOREVER);
        t_duty(0);
        t_duty(10);
        t_duty(30);
        t_duty(60);
        t_duty(-20);
        t_duty(-5);
        send(30);
        step(1);
        t_duty(10);
        step(1200);
        check("active forever", {15'h0, act}, 16'h0001);
        measure(2 * STEPS_C * exp_steps(10));
        wr_sel(1'b0);
        measure(0);
        wr_sel(1'b1);
        measure(2 * STEPS_C * exp_steps(10));
        t_expire(8'h01, 700);
        t_expire(8'h00, 400);
        wr_hold(HOLD_FOREVER);
        t_duty(20);
        t_reset();
        t_duty(30);
        results();
    end
endmodule : rssi_pwm_indicator_test

//--- rspi_pwm_sampler.sv
// Partner model: an indicator input that counts the high cycles of the pin.
module rspi_pwm_sampler (
    input  wire logic        core_clk_i,
    input  wire logic        pwm_i,
    input  wire logic        clear_i,
    output logic      [15:0] highs_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Counting over a whole number of periods makes the sum phase-free.
    always_ff @(posedge core_clk_i) begin
        if (clear_i) begin
            highs_o <= 16'h0000;
        end else if (pwm_i) begin
            highs_o <= highs_o + 16'h0001;
        end
    end
endmodule : rspi_pwm_sampler

//--- rspi_pwm_timebase.sv
// Step and period counter of the PWM output.
module rspi_pwm_timebase
    import rspi_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = rspi_pkg::STEP_CYC
) (
    input  wire logic  core_clk_i,
    input  wire logic  rst_n_i,
    rspi_tick_if.gen   tick
);
    logic [15:0] cyc_cnt;
    logic [15:0] next_cyc_cnt;
    rspi_step_t  step_cnt;
    rspi_step_t  next_step_cnt;
    logic        step_end;

    always_comb begin
        step_end      = (cyc_cnt == 16'(STEP_CYCLES - 1));
        next_cyc_cnt  = step_end ? 16'h0000 : cyc_cnt + 16'h0001;
        next_step_cnt = step_cnt;
        if (step_end) begin
            next_step_cnt = (step_cnt == LAST_STEP) ? 6'h00
                                                    : step_cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_cnt  <= 16'h0000;
            step_cnt <= 6'h00;
        end else begin
            cyc_cnt  <= next_cyc_cnt;
            step_cnt <= next_step_cnt;
        end
    end

    assign tick.step       = step_cnt;
    assign tick.period_end = step_end && (step_cnt == LAST_STEP);

    AST_PERIOD_LAST_STEP: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        tick.period_end |-> ##1 (step_cnt == 6'h00) && (cyc_cnt == 16'h0000))
        else $error("Period did not wrap to step zero.");
endmodule : rspi_pwm_timebase

//--- rspi_tick_if.sv
// Interface carrying the PWM time base from the step generator to the top.
interface rspi_tick_if;
    logic              period_end;
    rspi_pkg::rspi_step_t step;
    modport gen (output period_end, output step);
    modport use_side (input period_end, input step);
endinterface : rspi_tick_if
